/* File: rtl/cfw_pkg.sv */
// Purpose: Shared constants for the CAN window select and data filter count block
// Assumes: 16-bit register port, word index addressing
// Notes:   Offsets are register indices on the plain register port
package cfw_pkg;

    // Register port widths
    localparam int CFW_ADDR_W = 4;
    localparam int CFW_DATA_W = 16;

    // Register indices
    localparam logic [3:0] CFW_CTRL_ONE_OFS = 4'h0;
    localparam logic [3:0] CFW_CTRL_TWO_OFS = 4'h1;

    // Control one fields
    localparam int CFW_WIN_BIT = 0;

    // Control two fields
    localparam int CFW_CNT_LSB = 0;
    localparam int CFW_CNT_W   = 5;

    // Reset values
    localparam logic       CFW_WIN_RST = 1'b0;
    localparam logic [4:0] CFW_CNT_RST = 5'h00;

    // Counts above this are invalid selections
    localparam logic [4:0] CFW_CNT_MAX = 5'h11;

    // Compared bits (payload and identifier) and whole payload bits
    localparam int CFW_CMP_W     = 17;
    localparam int CFW_PAYLOAD_W = 24;

    // Bits of the payload that take part for a given count
    function automatic logic [CFW_CMP_W-1:0] cfw_cmp_mask(input logic [4:0] count);
        logic [CFW_CMP_W-1:0] mask;
        mask = '0;
        for (int k = 0; k < CFW_CMP_W; k++) begin
            if ((count <= CFW_CNT_MAX) && (k < int'(count))) begin
                mask[k] = 1'b1;
            end
        end
        return mask;
    endfunction

endpackage

/* File: rtl/cfw_data_cmp.sv */
// Purpose: Compare leading payload bits with extended identifier bits
// Assumes: Inputs come from logic on clk_in, no synchronisers needed
// Notes:   Result stands one cycle after the check strobe
`timescale 1ns/1ps
module cfw_data_cmp
    import cfw_pkg::*;
(
    input  wire logic                     clk_in,
    input  wire logic                     arst_n_in,
    input  wire logic [4:0]               data_filter_bit_count_in,
    input  wire logic [CFW_CMP_W-1:0]     extended_identifier_bits_in,
    input  wire logic [CFW_PAYLOAD_W-1:0] data_payload_in,
    input  wire logic                     check_in,
    output logic                          match_out,
    output logic                          match_valid_out
);
    logic [CFW_CMP_W-1:0] bit_equal;
    logic [CFW_CMP_W-1:0] cmp_mask;
    logic                 match_next;

    // transmission order pairing
    // Payload bit k in send order is byte one bit 7 downward
    genvar k;
    generate
        for (k = 0; k < CFW_CMP_W; k++) begin : g_pair
            assign bit_equal[k] = data_payload_in[CFW_PAYLOAD_W-1-k]
                                  == extended_identifier_bits_in[k];
        end
    endgenerate

    // zero count passes
    // Masked bits always agree, so an empty mask is identifier only
    assign cmp_mask   = cfw_cmp_mask(data_filter_bit_count_in);
    assign match_next = &(bit_equal | ~cmp_mask);

    // Result flops
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            match_out       <= 1'b0;
            match_valid_out <= 1'b0;
        end else begin
            match_valid_out <= check_in;
            if (check_in) begin
                match_out <= match_next;
            end
        end
    end

endmodule

/* File: rtl/cfw_filter_window_ctrl.sv */
// What this block does
// - Window select 1 maps the filter registers into the shared window, 0 the buffers.
// - A data filter bit count of zero compares identifier bits only, no payload.
// - A count of one compares first payload bit (byte one bit 7) with identifier bit 0.
// - A count of seventeen compares payload bits up to byte three against identifier bits.
// - Bits 15 to 5 of control two are unimplemented and read as zero.
//
// Purpose: Window select and data filter bit count control for a CAN controller
// Assumes: Single clk_in domain, plain register port with read data one cycle later
// Notes:   Filter inputs come from logic on the same clock
`timescale 1ns/1ps
module cfw_filter_window_ctrl
    import cfw_pkg::*;
(
    input  wire logic                          clk_in,
    input  wire logic                          arst_n_in,
    input  wire logic [cfw_pkg::CFW_ADDR_W-1:0] reg_addr_in,
    input  wire logic [cfw_pkg::CFW_DATA_W-1:0] reg_wdata_in,
    input  wire logic                          reg_wr_in,
    input  wire logic                          reg_rd_in,
    input  wire logic [cfw_pkg::CFW_CMP_W-1:0]  extended_identifier_bits_in,
    input  wire logic [cfw_pkg::CFW_PAYLOAD_W-1:0] data_payload_in,
    input  wire logic                          filter_check_in,
    output logic [cfw_pkg::CFW_DATA_W-1:0]     reg_rdata_out,
    output logic                               filter_window_out,
    output logic                               buffer_window_out,
    output logic [4:0]                         data_filter_bit_count_out,
    output logic                               data_match_out,
    output logic                               data_match_valid_out
);
    import cfw_pkg::*;

    // Register state
    logic                  map_window_select_reg;
    logic                  map_window_select_next;
    logic                  buffer_window_reg;
    logic [4:0]            data_filter_bit_count_reg;
    logic [4:0]            data_filter_bit_count_next;
    logic [CFW_DATA_W-1:0] rdata_reg;
    logic [CFW_DATA_W-1:0] rdata_next;

    // Address decode
    wire sel_ctrl_one = (reg_addr_in == CFW_CTRL_ONE_OFS);
    wire sel_ctrl_two = (reg_addr_in == CFW_CTRL_TWO_OFS);
    wire wr_ctrl_one  = reg_wr_in && sel_ctrl_one;
    wire wr_ctrl_two  = reg_wr_in && sel_ctrl_two;

    // Read views of both registers
    wire [CFW_DATA_W-1:0] ctrl_one_view;
    wire [CFW_DATA_W-1:0] ctrl_two_view;

    // reserved bits zero
    // Only the select bit exists here, everything above reads zero
    assign ctrl_one_view = {{(CFW_DATA_W-1){1'b0}}, map_window_select_reg};

    assign ctrl_two_view = {{(CFW_DATA_W-CFW_CNT_W){1'b0}}, data_filter_bit_count_reg};

    // Next values of the writable fields
    assign map_window_select_next = wr_ctrl_one ? reg_wdata_in[CFW_WIN_BIT]
                                                : map_window_select_reg;

    // invalid counts software side
    // Invalid counts are stored as written; the comparator treats them as no payload
    assign data_filter_bit_count_next =
        wr_ctrl_two ? reg_wdata_in[CFW_CNT_LSB +: CFW_CNT_W]
                    : data_filter_bit_count_reg;

    // Read mux; unmapped indices and idle cycles return zero
    assign rdata_next = !reg_rd_in   ? '0 :
                        sel_ctrl_one ? ctrl_one_view :
                        sel_ctrl_two ? ctrl_two_view : '0;

    // window select map
    // Both window enables are flops so neither output glitches on a write
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            map_window_select_reg <= CFW_WIN_RST;
            buffer_window_reg     <= !CFW_WIN_RST;
        end else begin
            map_window_select_reg <= map_window_select_next;
            buffer_window_reg     <= !map_window_select_next;
        end
    end

    // Count register
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            data_filter_bit_count_reg <= CFW_CNT_RST;
        end else begin
            data_filter_bit_count_reg <= data_filter_bit_count_next;
        end
    end

    // Read data stands for one cycle only
    // Zero between reads, so a late sample cannot pass for a fresh word
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_out             = rdata_reg;
    assign filter_window_out         = map_window_select_reg;
    assign buffer_window_out         = buffer_window_reg;
    assign data_filter_bit_count_out = data_filter_bit_count_reg;

    // seventeen bit compare
    // Comparator sees the stored count, so a write lands on the next check
    cfw_data_cmp u_data_cmp (
        .clk_in                      (clk_in),
        .arst_n_in                   (arst_n_in),
        .data_filter_bit_count_in    (data_filter_bit_count_reg),
        .extended_identifier_bits_in (extended_identifier_bits_in),
        .data_payload_in             (data_payload_in),
        .check_in                    (filter_check_in),
        .match_out                   (data_match_out),
        .match_valid_out             (data_match_valid_out)
    );

    // Helper for the checks: payload bit k in send order against identifier bit k
    logic [CFW_CMP_W-1:0] chk_equal;
    always_comb begin
        for (int i = 0; i < CFW_CMP_W; i++) begin
            chk_equal[i] = (data_payload_in[CFW_PAYLOAD_W-1-i]
                            == extended_identifier_bits_in[i]);
        end
    end

    // Checks sleep during reset; reset values are looked at from outside
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    // Writing the select bit moves both window enables next cycle
    property p_win_map;
        wr_ctrl_one |=> (filter_window_out == $past(reg_wdata_in[0]))
                        && (buffer_window_out == !$past(reg_wdata_in[0]));
    endproperty
    a_win_map: assert property (p_win_map)
        else $error("window enables do not follow select write");

    // Exactly one window is mapped at any time
    property p_win_excl;
        filter_window_out != buffer_window_out;
    endproperty
    a_win_excl: assert property (p_win_excl)
        else $error("both or neither window mapped");

    // Control one read returns zero in the unimplemented bits
    property p_ctrl_one_rsv;
        (reg_rd_in && sel_ctrl_one) |=> (reg_rdata_out[15:1] == 15'h0000)
            && (reg_rdata_out[0] == filter_window_out);
    endproperty
    a_ctrl_one_rsv: assert property (p_ctrl_one_rsv)
        else $error("control one read shows reserved bits");

    // Control two read returns zero above the count
    property p_ctrl_two_rsv;
        (reg_rd_in && sel_ctrl_two) |=> (reg_rdata_out[15:5] == 11'h000)
            && (reg_rdata_out[4:0] == data_filter_bit_count_out);
    endproperty
    a_ctrl_two_rsv: assert property (p_ctrl_two_rsv)
        else $error("control two read shows reserved bits");

    // Zero count always matches on identifier alone
    property p_zero_cnt;
        (filter_check_in && data_filter_bit_count_reg == 5'h00)
            |=> data_match_valid_out && data_match_out;
    endproperty
    a_zero_cnt: assert property (p_zero_cnt)
        else $error("zero count compared payload bits");

    // Count one compares byte one bit 7 with identifier bit 0
    property p_one_cnt;
        (filter_check_in && data_filter_bit_count_reg == 5'h01)
            |=> data_match_out == $past(data_payload_in[23] == extended_identifier_bits_in[0]);
    endproperty
    a_one_cnt: assert property (p_one_cnt)
        else $error("count one compare wrong");

    // Count seventeen compares all paired bits
    property p_full_cnt;
        (filter_check_in && data_filter_bit_count_reg == 5'h11)
            |=> data_match_out == $past(&chk_equal);
    endproperty
    a_full_cnt: assert property (p_full_cnt)
        else $error("count seventeen compare wrong");

    // For counts two to sixteen, a mismatch on the last counted bit fails the check
    property p_step_cnt;
        (filter_check_in && data_filter_bit_count_reg >= 5'h02
         && data_filter_bit_count_reg <= 5'h10
         && !chk_equal[data_filter_bit_count_reg - 5'h01])
            |=> !data_match_out;
    endproperty
    a_step_cnt: assert property (p_step_cnt)
        else $error("newest counted bit ignored");

    // Read data is zero unless a read came one cycle before
    property p_rd_once;
        !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000;
    endproperty
    a_rd_once: assert property (p_rd_once)
        else $error("read data outside its cycle");

    // Control one read shows the select as it stood at the read
    property p_win_read;
        (reg_rd_in && sel_ctrl_one) |=> reg_rdata_out[0] == $past(filter_window_out);
    endproperty
    a_win_read: assert property (p_win_read)
        else $error("select read back wrong");

    // Count field lands as written, upper write bits dropped
    property p_cnt_wr;
        wr_ctrl_two |=> data_filter_bit_count_out == $past(reg_wdata_in[4:0]);
    endproperty
    a_cnt_wr: assert property (p_cnt_wr)
        else $error("count write did not land");

    // Count holds between its own writes, other indices leave it alone
    property p_cnt_hold;
        !wr_ctrl_two |=> $stable(data_filter_bit_count_out);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold)
        else $error("count changed without a write");

    // Window select holds between its own writes
    property p_win_hold;
        !wr_ctrl_one |=> $stable(filter_window_out) && $stable(buffer_window_out);
    endproperty
    a_win_hold: assert property (p_win_hold)
        else $error("window moved without a write");

    // Unmapped indices read back as zero
    property p_rd_unmapped;
        (reg_rd_in && !sel_ctrl_one && !sel_ctrl_two) |=> reg_rdata_out == 16'h0000;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped)
        else $error("unmapped index returned data");

    // Every check gives exactly one result strobe, one cycle later
    property p_valid_set;
        filter_check_in |=> data_match_valid_out;
    endproperty
    a_valid_set: assert property (p_valid_set)
        else $error("result strobe missing after check");

    // No strobe without a check, so a stale result is never flagged new
    property p_valid_idle;
        !filter_check_in |=> !data_match_valid_out;
    endproperty
    a_valid_idle: assert property (p_valid_idle)
        else $error("result strobe without check");

    // Result stands until the next check
    property p_match_hold;
        !filter_check_in |=> $stable(data_match_out);
    endproperty
    a_match_hold: assert property (p_match_hold)
        else $error("result changed without check");

    // Mask of the counted bits, built apart from the comparator's own decode
    // so a fault in the shared function cannot hide itself here
    logic [CFW_CMP_W-1:0] chk_low_mask;
    genvar m;
    generate
        for (m = 0; m < CFW_CMP_W; m++) begin : g_chk_mask
            assign chk_low_mask[m] = (int'(data_filter_bit_count_reg) > m);
        end
    endgenerate

    // Valid count and all counted bits equal: the check passes
    property p_step_pass;
        (filter_check_in && data_filter_bit_count_reg >= 5'h01
         && data_filter_bit_count_reg <= 5'h11
         && (chk_equal & chk_low_mask) == chk_low_mask)
            |=> data_match_out;
    endproperty
    a_step_pass: assert property (p_step_pass)
        else $error("counted bits agree but check failed");

    // Valid count and any counted bit different: the check fails
    property p_step_fail;
        (filter_check_in && data_filter_bit_count_reg >= 5'h01
         && data_filter_bit_count_reg <= 5'h11
         && (chk_equal & chk_low_mask) != chk_low_mask)
            |=> !data_match_out;
    endproperty
    a_step_fail: assert property (p_step_fail)
        else $error("counted bit differs but check passed");

    // Main scenarios
    c_filter_window: cover property (wr_ctrl_one && reg_wdata_in[0] ##1 filter_window_out);
    c_full_match:    cover property (filter_check_in && data_filter_bit_count_reg == 5'h11
                                     ##1 data_match_out);
    c_step_miss:     cover property (filter_check_in && data_filter_bit_count_reg == 5'h08
                                     ##1 !data_match_out);
    c_back_to_back:  cover property (wr_ctrl_two ##1 (reg_rd_in && sel_ctrl_two));
    c_zero_count:    cover property (filter_check_in && data_filter_bit_count_reg == 5'h00
                                     ##1 data_match_out);

endmodule

/* File: verification/cfw_filter_window_ctrl_tb.sv */
// Purpose: Self-checking bench for the window select and data filter count block
// Assumes: Register read data stands only in the cycle after the read strobe
// Notes:   Register cases run from a table; compare and reset cases are hand-written
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module cfw_filter_window_ctrl_tb;
    import cfw_pkg::*;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic        map_window_select;
    } cfw_row_t;

    // Identifier pattern, not symmetric so a reversed bit order shows
    localparam logic [16:0] EID_PAT = 17'h1B2C5;

    logic        clk_in      = 1'b0;
    logic        arst_n_in   = 1'b0;
    logic [3:0]  reg_addr_in = 4'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic        reg_wr_in   = 1'b0;
    logic        reg_rd_in   = 1'b0;
    logic [16:0] eid_in      = 17'h00000;
    logic [23:0] payload_in  = 24'h000000;
    logic        check_in    = 1'b0;
    logic [15:0] rdata;
    logic        filter_win;
    logic        buffer_win;
    logic [4:0]  count;
    logic        match;
    logic        match_valid;
    logic [15:0] rd_val;
    logic [23:0] pay;
    int          err_count   = 0;
    int          cmp_count   = 0;

    // Writes, then reads back; last row hits an unmapped index
    cfw_row_t rows [6] = '{
        '{4'h0, 16'h0001, 16'h0001, 1'b1},
        '{4'h0, 16'hFFFE, 16'h0000, 1'b0},
        '{4'h0, 16'h0007, 16'h0001, 1'b1},
        '{4'h1, 16'hFFEF, 16'h000F, 1'b1}, // only valid counts written
        '{4'h1, 16'h0011, 16'h0011, 1'b1},
        '{4'h2, 16'hFFFF, 16'h0000, 1'b1}
    };

    // 10 MHz clock
    always #50 clk_in = ~clk_in;

    cfw_filter_window_ctrl u_dut (
        .clk_in                      (clk_in),
        .arst_n_in                   (arst_n_in),
        .reg_addr_in                 (reg_addr_in),
        .reg_wdata_in                (reg_wdata_in),
        .reg_wr_in                   (reg_wr_in),
        .reg_rd_in                   (reg_rd_in),
        .extended_identifier_bits_in (eid_in),
        .data_payload_in             (payload_in),
        .filter_check_in             (check_in),
        .reg_rdata_out               (rdata),
        .filter_window_out           (filter_win),
        .buffer_window_out           (buffer_win),
        .data_filter_bit_count_out   (count),
        .data_match_out              (match),
        .data_match_valid_out        (match_valid)
    );

    // One-cycle write strobe; outputs settle at the closing edge
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
        #1;
    endtask

    // Read data is taken in the only cycle where it stands
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_in);
        reg_rd_in   <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        d = rdata;
    endtask

    // One compare request and its result one cycle later
    task automatic chk(input logic [23:0] p, input logic exp_m);
        @(posedge clk_in);
        check_in   <= 1'b1;
        eid_in     <= EID_PAT;
        payload_in <= p;
        @(posedge clk_in);
        check_in <= 1'b0;
        #1;
        `CHK("match valid", 1'b1, match_valid) // result strobe
        `CHK("match", exp_m, match) // result
    endtask

    // Payload whose leading seventeen bits equal the identifier bits
    function automatic logic [23:0] mk(input logic [16:0] e);
        logic [23:0] p;
        p = 24'h00002A;
        for (int k = 0; k < 17; k++) begin
            p[23-k] = e[k];
        end
        return p;
    endfunction

    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard, far beyond the length of the sequence
    initial begin
        #5000000;
        err_count++;
        results();
    end

    initial begin
        repeat (5) @(posedge clk_in);
        #1;
        `CHK("reset window", 1'b0, filter_win) // buffers after reset
        `CHK("reset buffer", 1'b1, buffer_win) // buffers after reset
        `CHK("reset count", 5'h00, count) // count clear
        `CHK("reset read data", 16'h0000, rdata) // read idle
        `CHK("reset match", 1'b0, match) // result clear
        `CHK("reset match valid", 1'b0, match_valid) // no result
        @(posedge clk_in);
        arst_n_in <= 1'b1;
        // Table of register cases
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            `CHK("filter window", rows[i].map_window_select, filter_win) // window map
            `CHK("buffer window", ~rows[i].map_window_select, buffer_win) // window map
            rd(rows[i].addr, rd_val);
            `CHK("read data", rows[i].rdata, rd_val) // read zero
        end
        `CHK("stored count", 5'h11, count) // count kept
        @(posedge clk_in);
        #1;
        `CHK("idle read data", 16'h0000, rdata) // one cycle only
        // Count zero ignores a fully mismatched payload
        wr(4'h1, 16'h0000);
        chk(~mk(EID_PAT), 1'b1);
        // Counts one to seventeen: last included bit decides, next bit does not
        for (int n = 1; n <= 17; n++) begin
            wr(4'h1, 16'(n));
            pay = mk(EID_PAT);
            chk(pay, 1'b1);
            chk(pay ^ (24'h800000 >> (n - 1)), 1'b0);
            chk(pay ^ (24'h800000 >> n), 1'b1);
        end
        @(posedge clk_in);
        #1;
        `CHK("valid pulse end", 1'b0, match_valid) // one-cycle strobe
        // Back to back: count write, then read and check in the next cycle
        @(posedge clk_in);
        reg_wr_in    <= 1'b1;
        reg_addr_in  <= 4'h1;
        reg_wdata_in <= 16'h0003;
        @(posedge clk_in);
        reg_wr_in    <= 1'b0;
        reg_rd_in    <= 1'b1;
        check_in     <= 1'b1;
        payload_in   <= mk(EID_PAT) ^ 24'h200000;
        @(posedge clk_in);
        reg_rd_in    <= 1'b0;
        check_in     <= 1'b0;
        #1;
        `CHK("back to back read", 16'h0003, rdata) // new count read
        `CHK("back to back match", 1'b0, match) // new count used
        // Reset in mid-run clears the window and count
        wr(4'h0, 16'h0001);
        @(posedge clk_in);
        arst_n_in <= 1'b0;
        #1;
        `CHK("mid reset window", 1'b0, filter_win) // buffers after reset
        `CHK("mid reset count", 5'h00, count) // count clear
        @(posedge clk_in);
        arst_n_in <= 1'b1;
        // First edge after release keeps reset values, then a write lands
        @(posedge clk_in);
        #1;
        `CHK("release buffer", 1'b1, buffer_win) // buffers after reset
        `CHK("release read data", 16'h0000, rdata) // read idle
        `CHK("release valid", 1'b0, match_valid) // no result
        wr(4'h0, 16'h0001);
        `CHK("release window", 1'b1, filter_win) // window map
        results();
    end
endmodule
